// ---- iodov_params.svh ----
`ifndef IODOV_PARAMS_SVH
`define IODOV_PARAMS_SVH

`define IODOV_NUM_PINS    3
`define IODOV_ADDR_W      16
`define IODOV_DATA_W      32
`define IODOV_CFG_IDX     16'h0469
`define IODOV_CFG_ADDR    (`IODOV_CFG_IDX * 16'h0004)
`define IODOV_FIELD_W     4
`define IODOV_EN_BIT      0
`define IODOV_VAL_BIT     1
`define IODOV_POL_BIT     2
`define IODOV_LANE_W      8
`define IODOV_EN_RST      1'b0
`define IODOV_VAL_RST     1'b0
`define IODOV_POL2_RST    1'b0
`define IODOV_STRAP_W     2

`endif

// ---- iodov_pkg.sv ----
package iodov_pkg;

  typedef enum logic [1:0] {
    IODOV_RESP_OKAY   = 2'b00,
    IODOV_RESP_SLVERR = 2'b10
  } iodov_resp_e;

  typedef logic [2:0] iodov_pins_t;

endpackage

// ---- iodov_strap_if.sv ----
`timescale 1ns/100ps
`include "iodov_params.svh"

interface iodov_strap_if;
  logic [`IODOV_STRAP_W-1:0] filt;

  modport sync_mp (output filt);
  modport core_mp (input filt);
endinterface

// ---- iodov_strap_sync.sv ----
`timescale 1ns/100ps
`include "iodov_params.svh"

module iodov_strap_sync (
  input  wire logic                      mclk_i,   // System clock.
  input  wire logic [`IODOV_STRAP_W-1:0] strap_i,  // Bootstrap pins, asynchronous.
  iodov_strap_if.sync_mp                 strap     // Filtered strap levels.
);

  // The chain is not reset so the strap level keeps flowing while reset is held.
  logic [`IODOV_STRAP_W-1:0] s1_q;
  logic [`IODOV_STRAP_W-1:0] s2_q;
  logic [`IODOV_STRAP_W-1:0] s3_q;
  logic [`IODOV_STRAP_W-1:0] filt_q;
  logic [`IODOV_STRAP_W-1:0] filt_d;

  always_comb begin
    filt_d = filt_q;
    for (int b = 0; b < `IODOV_STRAP_W; b++) begin
      if (s2_q[b] == s3_q[b]) begin
        filt_d[b] = s2_q[b];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    s1_q   <= strap_i;
    s2_q   <= s1_q;
    s3_q   <= s2_q;
    filt_q <= filt_d;
  end

  assign strap.filt = filt_q;

endmodule

// ---- iodov_indicator.sv ----
// Operation
// RULE1 - Polarity bit: 1 active high, 0 active low.
// RULE2 - Override enable 1 forces pin, 0 normal.
// RULE3 - Forced-level bit: 1 drives high, 0 low.
// RULE4 - Pins 0,1 polarity from straps; pin 2 zero.
// RULE5 - Override enable and value reset to zero.
// RULE6 - Forced level bypasses polarity inversion.
`timescale 1ns/100ps
`include "iodov_params.svh"

module iodov_indicator (
  input  wire logic                      mclk_i,            // System clock, 20 MHz.
  input  wire logic                      srst_i,            // Synchronous reset, active high.
  input  wire logic [`IODOV_STRAP_W-1:0] strap_i,           // Bootstrap pins for pins 0 and 1.
  input  wire logic [2:0]                src_i,             // Normal indication sources, active high.
  output logic                           indicator_out_0_o, // Indicator pin 0.
  output logic                           indicator_out_1_o, // Indicator pin 1.
  output logic                           indicator_out_2_o, // Indicator pin 2.
  input  wire logic [`IODOV_ADDR_W-1:0]  s_axi_awaddr_i,    // Write address.
  input  wire logic                      s_axi_awvalid_i,   // Write address valid.
  output logic                           s_axi_awready_o,   // Write address ready.
  input  wire logic [`IODOV_DATA_W-1:0]  s_axi_wdata_i,     // Write data.
  input  wire logic [3:0]                s_axi_wstrb_i,     // Write byte strobes.
  input  wire logic                      s_axi_wvalid_i,    // Write data valid.
  output logic                           s_axi_wready_o,    // Write data ready.
  output logic [1:0]                     s_axi_bresp_o,     // Write response.
  output logic                           s_axi_bvalid_o,    // Write response valid.
  input  wire logic                      s_axi_bready_i,    // Write response ready.
  input  wire logic [`IODOV_ADDR_W-1:0]  s_axi_araddr_i,    // Read address.
  input  wire logic                      s_axi_arvalid_i,   // Read address valid.
  output logic                           s_axi_arready_o,   // Read address ready.
  output logic [`IODOV_DATA_W-1:0]       s_axi_rdata_o,     // Read data.
  output logic [1:0]                     s_axi_rresp_o,     // Read response.
  output logic                           s_axi_rvalid_o,    // Read data valid.
  input  wire logic                      s_axi_rready_i     // Read data ready.
);

  iodov_strap_if strap ();

  iodov_strap_sync u_sync (
    .mclk_i  (mclk_i),
    .strap_i (strap_i),
    .strap   (strap.sync_mp)
  );

  iodov_pkg::iodov_pins_t en_q, en_d;
  iodov_pkg::iodov_pins_t val_q, val_d;
  iodov_pkg::iodov_pins_t pol_q, pol_d;
  iodov_pkg::iodov_pins_t ind_q, ind_d;

  logic                     aw_got_q, aw_got_d;
  logic                     w_got_q, w_got_d;
  logic [`IODOV_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [`IODOV_DATA_W-1:0] wdata_q, wdata_d;
  logic [3:0]               wstrb_q, wstrb_d;
  logic                     awready_q, awready_d;
  logic                     wready_q, wready_d;
  logic                     bvalid_q, bvalid_d;
  iodov_pkg::iodov_resp_e   bresp_q, bresp_d;
  logic                     arready_q, arready_d;
  logic                     rvalid_q, rvalid_d;
  logic [`IODOV_DATA_W-1:0] rdata_q, rdata_d;
  iodov_pkg::iodov_resp_e   rresp_q, rresp_d;

  logic                     do_wr;
  logic                     wr_hit;
  logic [`IODOV_DATA_W-1:0] cfg_word;

  assign do_wr  = aw_got_q && w_got_q && !bvalid_q;
  assign wr_hit = do_wr && (awaddr_q == `IODOV_CFG_ADDR);

  // Reserved bits of each nibble read as zero.
  always_comb begin
    cfg_word = '0;
    for (int i = 0; i < `IODOV_NUM_PINS; i++) begin
      cfg_word[i*`IODOV_FIELD_W + `IODOV_EN_BIT]  = en_q[i];
      cfg_word[i*`IODOV_FIELD_W + `IODOV_VAL_BIT] = val_q[i];
      cfg_word[i*`IODOV_FIELD_W + `IODOV_POL_BIT] = pol_q[i];
    end
  end

  // Configuration register and pin stage.
  always_comb begin
    en_d  = en_q;
    val_d = val_q;
    pol_d = pol_q;
    ind_d = ind_q;
    if (srst_i) begin
      en_d  = {`IODOV_NUM_PINS{`IODOV_EN_RST}};            // RULE5
      val_d = {`IODOV_NUM_PINS{`IODOV_VAL_RST}};           // RULE5
      pol_d = {`IODOV_POL2_RST, strap.filt};               // RULE4
    end else if (wr_hit) begin
      for (int i = 0; i < `IODOV_NUM_PINS; i++) begin
        if (wstrb_q[(i*`IODOV_FIELD_W)/`IODOV_LANE_W]) begin
          en_d[i]  = wdata_q[i*`IODOV_FIELD_W + `IODOV_EN_BIT];  // RULE2
          val_d[i] = wdata_q[i*`IODOV_FIELD_W + `IODOV_VAL_BIT]; // RULE3
          pol_d[i] = wdata_q[i*`IODOV_FIELD_W + `IODOV_POL_BIT]; // RULE1
        end
      end
    end
    for (int i = 0; i < `IODOV_NUM_PINS; i++) begin
      if (en_q[i]) begin                                   // RULE2
        ind_d[i] = val_q[i];                               // RULE3 RULE6
      end else begin
        ind_d[i] = pol_q[i] ? src_i[i] : !src_i[i];        // RULE1
      end
    end
  end

  // Write channel: address and data are held until both have arrived.
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    if (s_axi_awvalid_i && awready_q) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_q) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata_i;
      wstrb_d = s_axi_wstrb_i;
    end
    if (do_wr) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = wr_hit ? iodov_pkg::IODOV_RESP_OKAY : iodov_pkg::IODOV_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_got_d && !bvalid_d;
    wready_d  = !w_got_d && !bvalid_d;
  end

  // Read channel: one read in flight, answered the cycle after it is taken.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid_i && arready_q) begin
      rvalid_d = 1'b1;
      if (s_axi_araddr_i == `IODOV_CFG_ADDR) begin
        rdata_d = cfg_word;
        rresp_d = iodov_pkg::IODOV_RESP_OKAY;
      end else begin
        rdata_d = '0;
        rresp_d = iodov_pkg::IODOV_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge mclk_i) begin
    en_q  <= en_d;
    val_q <= val_d;
    pol_q <= pol_d;
    ind_q <= ind_d;
    if (srst_i) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= iodov_pkg::IODOV_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= iodov_pkg::IODOV_RESP_OKAY;
    end else begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign indicator_out_0_o = ind_q[0];
  assign indicator_out_1_o = ind_q[1];
  assign indicator_out_2_o = ind_q[2];
  assign s_axi_awready_o   = awready_q;
  assign s_axi_wready_o    = wready_q;
  assign s_axi_bvalid_o    = bvalid_q;
  assign s_axi_bresp_o     = bresp_q;
  assign s_axi_arready_o   = arready_q;
  assign s_axi_rvalid_o    = rvalid_q;
  assign s_axi_rdata_o     = rdata_q;
  assign s_axi_rresp_o     = rresp_q;

  for (genvar g = 0; g < `IODOV_NUM_PINS; g++) begin : g_chk
    forced_level_a : assert property (@(posedge mclk_i) disable iff (srst_i) // RULE3
      en_q[g] |=> ind_q[g] == $past(val_q[g]))
      else $error("forced level not on pin");
    normal_polarity_a : assert property (@(posedge mclk_i) disable iff (srst_i) // RULE1
      !en_q[g] |=> ind_q[g] == ($past(src_i[g]) ^ !$past(pol_q[g])))
      else $error("normal source polarity wrong");
    no_invert_a : assert property (@(posedge mclk_i) disable iff (srst_i) // RULE6
      (en_q[g] && !pol_q[g] && val_q[g]) |=> ind_q[g])
      else $error("forced level was inverted");
  end

  reset_clear_a : assert property (@(posedge mclk_i) // RULE5
    srst_i |=> (en_q == '0) && (val_q == '0) && !pol_q[2])
    else $error("override bits not cleared by reset");

  // Checked at release only: the strap chain has no reset, so it is unknown for the first edges after power-up.
  strap_load_a : assert property (@(posedge mclk_i) // RULE4
    $fell(srst_i) |-> pol_q[1:0] == $past(strap.filt))
    else $error("polarity not loaded from straps");

  enable_write_a : assert property (@(posedge mclk_i) disable iff (srst_i) // RULE2
    (wr_hit && wstrb_q[(2*`IODOV_FIELD_W)/`IODOV_LANE_W]) |=>
      en_q[2] == $past(wdata_q[2*`IODOV_FIELD_W + `IODOV_EN_BIT]))
    else $error("override enable not written");

  write_resp_a : assert property (@(posedge mclk_i) disable iff (srst_i)
    (s_axi_awvalid_i && awready_q && s_axi_wvalid_i && wready_q) |=> ##1 bvalid_q)
    else $error("write response late");

endmodule

// ---- iodov_lamp_model.sv ----
`timescale 1ns/100ps

module iodov_lamp_model (
  input  wire logic       mclk_i, // System clock.
  input  wire logic [2:0] pins_i, // Indicator pin levels.
  output logic      [2:0] lit_o   // Lamp states.
);
  // Lamps only follow the pins and never drive anything back into the block.
  always_ff @(posedge mclk_i) begin
    lit_o <= pins_i;
  end
endmodule

// ---- iodov_indicator_tb.sv ----
`timescale 1ns/100ps
`include "iodov_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module iodov_indicator_tb;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [1:0]  strap, bresp, rresp;
  logic [2:0]  src, pins, lit;
  logic [3:0]  strb, ws;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, cfg, d;
  logic        awvalid, wvalid, bready, arvalid, rready, pin_chk;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  int          n_fail = 0;
  int          tests_run = 0;

  always #25 mclk_i = ~mclk_i;

  iodov_indicator DUT (
    .mclk_i(mclk_i), .srst_i(srst_i), .strap_i(strap), .src_i(src),
    .indicator_out_0_o(pins[0]), .indicator_out_1_o(pins[1]), .indicator_out_2_o(pins[2]),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
  );

  iodov_lamp_model lamp (.mclk_i(mclk_i), .pins_i(pins), .lit_o(lit));

  // The driver is strictly sequential, so at most one kind of result shows per edge.
  always @(posedge mclk_i) begin
    if (bvalid && bready) begin
      e = exp_q.pop_front();
      `CHK(bresp, e[1:0])
    end
    if (rvalid && rready) begin
      e = exp_q.pop_front();
      `CHK({rresp, rdata}, e)
    end
    if (pin_chk) begin
      e = exp_q.pop_front();
      `CHK({lit, pins}, {e[2:0], e[2:0]})
    end
  end

  function automatic logic [2:0] pin_exp(input logic [31:0] c, input logic [2:0] s);
    for (int i = 0; i < 3; i++)
      pin_exp[i] = c[4*i] ? c[4*i+1] : (c[4*i+2] ? s[i] : ~s[i]);
  endfunction

  task automatic finish_test();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic give_up(input int n);
    if (n >= 50) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] dt, input logic [3:0] s, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk_i);
    exp_q.push_back({32'h0, r});
    awaddr <= a;
    wdata <= dt;
    strb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bvalid && n < 50) begin
      @(posedge mclk_i);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    give_up(n);
  endtask

  task automatic rd(input logic [15:0] a, input logic [33:0] x);
    int n;
    n = 0;
    @(posedge mclk_i);
    exp_q.push_back(x);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rvalid && n < 50) begin
      @(posedge mclk_i);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    give_up(n);
  endtask

  // Fresh sources each time, then a few edges so the registered pins settle.
  task automatic pchk(input logic [31:0] c);
    @(posedge mclk_i);
    src <= 3'($urandom);
    repeat (3) @(posedge mclk_i);
    exp_q.push_back({31'h0, pin_exp(c, src)});
    pin_chk <= 1'b1;
    @(posedge mclk_i);
    pin_chk <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge mclk_i);
    strap <= 2'($urandom);
    srst_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    cfg = {25'h0, strap[1], 3'h0, strap[0], 2'h0};
  endtask

  initial begin
    {awaddr, araddr, wdata, src, strap, strb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, pin_chk} = '0;
    void'($urandom(74));
    do_reset();
    rd(`IODOV_CFG_ADDR, {2'b00, cfg});
    pchk(cfg);
    repeat (16) begin
      d = $urandom;
      ws = 4'($urandom);
      // Lane 0 carries pins 0 and 1, lane 1 carries pin 2; an unstrobed lane keeps its old bits.
      cfg = ((ws[0] ? d : cfg) & 32'h0000_0077) | ((ws[1] ? d : cfg) & 32'h0000_0700);
      wr(`IODOV_CFG_ADDR, d, ws, 2'b00);
      rd(`IODOV_CFG_ADDR, {2'b00, cfg});
      pchk(cfg);
    end
    // Unmapped place: refused and leaves the configuration alone.
    wr(16'h0000, 32'hffff_ffff, 4'hf, 2'b10);
    rd(16'h0000, {2'b10, 32'h0});
    rd(`IODOV_CFG_ADDR, {2'b00, cfg});
    do_reset();
    rd(`IODOV_CFG_ADDR, {2'b00, cfg});
    pchk(cfg);
    finish_test();
  end
endmodule
